// >>> design/afp_fan_pwm.sv
// Three-channel fan PWM with auto curve, spin-up and ramp limiting
`timescale 1ns/10ps
`default_nettype none
module afp_fan_pwm #(
   parameter int unsigned NCH = 3
) (
   // Clock and reset
   input  wire logic              CORE_CLK_I,
   input  wire logic              RST_N_I,
   // Wishbone slave
   input  wire logic              WB_CYC_I,
   input  wire logic              WB_STB_I,
   input  wire logic              WB_WE_I,
   input  wire logic [9:0]        WB_ADR_I,
   input  wire logic [3:0]        WB_SEL_I,
   input  wire logic [31:0]       WB_DAT_I,
   output logic      [31:0]       WB_DAT_O,
   output logic                   WB_ACK_O,
   // Zone temperatures, signed degrees
   input  wire logic [3*8-1:0]    ZONE_TEMP_I,
   // Per-channel tach below minimum, already combined per channel
   input  wire logic [NCH-1:0]    TACH_OK_I,
   // Channel starting from standstill request
   input  wire logic [NCH-1:0]    FAN_START_I,
   // Fan outputs
   output logic      [NCH-1:0]    FAN_PWM_O
);
   import afp_pkg::*;

   // Reset release synchroniser
   logic [1:0] rst_sync_q;
   wire        rst_n = rst_sync_q[1];
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) rst_sync_q <= 2'b00;
      else          rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   // Input synchronisers for pins
   logic [NCH-1:0] tach_s1_q, tach_s2_q, start_s1_q, start_s2_q;
   logic [23:0]    temp_s1_q, temp_s2_q;
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         tach_s1_q  <= '0;
         tach_s2_q  <= '0;
         start_s1_q <= '0;
         start_s2_q <= '0;
         temp_s1_q  <= '0;
         temp_s2_q  <= '0;
      end else begin
         tach_s1_q  <= TACH_OK_I;
         tach_s2_q  <= tach_s1_q;
         start_s1_q <= FAN_START_I;
         start_s2_q <= start_s1_q;
         temp_s1_q  <= ZONE_TEMP_I;
         temp_s2_q  <= temp_s1_q;
      end
   end

   // Register storage
   logic [7:0] cfg_q [NCH];
   logic [7:0] rf_q  [NCH];
   logic [7:0] min_q [NCH];
   logic [7:0] low_q [NCH];
   logic [7:0] abs_q [NCH];
   logic [7:0] man_q [NCH];
   logic [7:0] ramp1_q, ramp23_q, gcfg_q;
   logic [7:0] duty_q [NCH];
   logic       ack_q;

   // Bus decode
   afp_req_s req;
   assign req.adr = WB_ADR_I[9:2];
   assign req.we  = WB_WE_I;
   assign req.dat = WB_DAT_I[7:0];
   wire bus_go   = WB_CYC_I & WB_STB_I & ~ack_q;
   wire wr_go    = bus_go & req.we & WB_SEL_I[0];
   wire locked   = gcfg_q[GCFG_LOCK_BIT];
   wire early_en = gcfg_q[GCFG_STARTUP_EARLY_END_ENABLE_BIT];

   // Read mux
   logic [7:0] rd_data;
   always_comb begin
      rd_data = 8'h00;
      for (int k = 0; k < NCH; k++) begin
         if (req.adr == OFS_CFG1 + 8'(k))        rd_data = cfg_q[k];
         if (req.adr == OFS_RANGE_FREQ1 + 8'(k)) rd_data = rf_q[k];
         if (req.adr == OFS_MIN1 + 8'(k))        rd_data = min_q[k];
         if (req.adr == OFS_LOW1 + 8'(k))        rd_data = low_q[k];
         if (req.adr == OFS_ABS1 + 8'(k))        rd_data = abs_q[k];
         if (req.adr == OFS_DUTY1 + 8'(k))       rd_data = duty_q[k];
      end
      if (req.adr == OFS_RAMP1)  rd_data = ramp1_q;
      if (req.adr == OFS_RAMP23) rd_data = ramp23_q;
      if (req.adr == OFS_GCFG)   rd_data = gcfg_q;
   end

   // Bus answer, one wait cycle, unmapped reads give zero
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ack_q    <= 1'b0;
         WB_DAT_O <= '0;
      end else begin
         ack_q    <= bus_go;
         WB_DAT_O <= {24'h000000, rd_data};
      end
   end
   assign WB_ACK_O = ack_q;

   // Global registers; lock is sticky until reset
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ramp1_q  <= RST_RAMP1;
         ramp23_q <= RST_RAMP23;
         gcfg_q   <= RST_GCFG;
      end else if (wr_go) begin
         if (req.adr == OFS_RAMP1 && !locked)  ramp1_q  <= {4'he, req.dat[3:0]};
         if (req.adr == OFS_RAMP23 && !locked) ramp23_q <= req.dat;
         if (req.adr == OFS_GCFG) gcfg_q <= req.dat | {6'h00, locked, 1'b0};
      end
   end

   // Zone temperatures, absolute overrun and auto-mode detection
   logic [7:0] ztemp [3];
   logic [2:0] over_abs;
   logic       any_auto;
   always_comb begin
      any_auto = 1'b0;
      for (int z = 0; z < 3; z++) begin
         ztemp[z]    = temp_s2_q[z*8 +: 8];
         over_abs[z] = (abs_q[z] != ABS_OFF) && ($signed(ztemp[z]) > $signed(abs_q[z]));
      end
      for (int k = 0; k < NCH; k++) begin
         if (cfg_q[k][7:5] != MODE_FULL && cfg_q[k][7:5] != MODE_OFF
             && cfg_q[k][7:5] != MODE_MANUAL) any_auto = 1'b1;
      end
   end
   wire force_full = any_auto & (|over_abs);

   // Auto curve for zone z with channel minimum m
   function automatic logic [7:0] curve(input logic [7:0] t, input logic [7:0] lo,
                                        input logic [3:0] rc, input logic [7:0] m);
      logic signed [9:0] dt;
      logic [31:0]       prod;
      logic [31:0]       inc;
      dt   = 10'($signed(t)) - 10'($signed(lo));
      prod = 32'(255 - m) * 32'(dt[7:0]) * 32'd100;
      inc  = prod / RANGE_CD[rc];
      if (dt <= 0)                                  curve = m;
      else if (dt >= 10'(RANGE_CEIL[rc]))           curve = 8'hff;
      else if (32'(m) + inc >= 32'd255)             curve = 8'hff;
      else                                          curve = 8'(32'(m) + inc);
   endfunction

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         // Per-channel register writes
         wire [7:0] cfg_adr = OFS_CFG1 + 8'(g);
         wire [7:0] rf_adr  = OFS_RANGE_FREQ1 + 8'(g);
         always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
            if (!rst_n) begin
               cfg_q[g] <= RST_CFG;
               rf_q[g]  <= RST_RANGE_FREQ;
               min_q[g] <= RST_MIN;
               low_q[g] <= RST_LOW;
               abs_q[g] <= RST_ABS;
               man_q[g] <= 8'h00;
            end else if (wr_go) begin
               if (!locked && req.adr == cfg_adr)           cfg_q[g] <= req.dat;
               if (!locked && req.adr == rf_adr)            rf_q[g]  <= req.dat;
               if (!locked && req.adr == OFS_MIN1 + 8'(g))  min_q[g] <= req.dat;
               if (!locked && req.adr == OFS_LOW1 + 8'(g))  low_q[g] <= req.dat;
               if (!locked && req.adr == OFS_ABS1 + 8'(g))  abs_q[g] <= req.dat;
               if (req.adr == OFS_DUTY1 + 8'(g))            man_q[g] <= req.dat;
            end
         end

         // Ramp field per channel
         wire [3:0] ramp_nib = (g == 0) ? ramp1_q[3:0] :
                               (g == 1) ? ramp23_q[7:4] : ramp23_q[3:0];
         wire       slew_en   = ramp_nib[3];
         wire [2:0] slew_code = ramp_nib[2:0];

         // Target duty from mode
         wire [7:0] cv1 = curve(ztemp[0], low_q[0], rf_q[0][7:4], min_q[g]);
         wire [7:0] cv2 = curve(ztemp[1], low_q[1], rf_q[1][7:4], min_q[g]);
         wire [7:0] cv3 = curve(ztemp[2], low_q[2], rf_q[2][7:4], min_q[g]);
         wire [7:0] hot23  = (cv2 > cv3) ? cv2 : cv3;
         wire [7:0] hot123 = (cv1 > hot23) ? cv1 : hot23;
         afp_mode_e mode;
         logic [7:0] target;
         assign mode = afp_mode_e'(cfg_q[g][7:5]);
         always_comb begin
            case (mode)
               MODE_Z1:     target = over_abs[0] ? 8'hff : cv1;
               MODE_Z2:     target = over_abs[1] ? 8'hff : cv2;
               MODE_Z3:     target = over_abs[2] ? 8'hff : cv3;
               MODE_FULL:   target = 8'hff;
               MODE_OFF:    target = 8'h00;
               MODE_HOT23:  target = hot23;
               MODE_HOT123: target = hot123;
               MODE_MANUAL: target = man_q[g];
               default:     target = 8'h00;
            endcase
            if (force_full && mode != MODE_OFF) target = 8'hff;
         end

         // Ramp interval timer
         logic [31:0] step_cnt_q;
         wire  [31:0] step_len = 32'(STEP_MS[slew_code] * CYC_PER_MS);
         wire         step_tick = (step_cnt_q >= step_len - 32'd1);
         always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
            if (!rst_n)         step_cnt_q <= '0;
            else if (step_tick) step_cnt_q <= '0;
            else                step_cnt_q <= step_cnt_q + 32'd1;
         end

         // Spin-up state machine
         afp_state_e  st_q;
         logic [31:0] spin_cnt_q;
         wire  [31:0] spin_len = 32'(SPIN_MS[cfg_q[g][2:0]] * CYC_PER_MS);
         wire spin_done = (spin_cnt_q >= spin_len)
                        | (early_en & tach_s2_q[g]);
         always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
            if (!rst_n) begin
               st_q       <= ST_IDLE;
               spin_cnt_q <= '0;
            end else begin
               case (st_q)
                  ST_IDLE: begin
                     spin_cnt_q <= '0;
                     if (start_s2_q[g] && mode != MODE_OFF) st_q <= ST_SPIN;
                     else st_q <= ST_RUN;
                  end
                  ST_SPIN: begin
                     spin_cnt_q <= spin_cnt_q + 32'd1;
                     // A disabled channel drops spin-up so its pin goes idle
                     if (spin_done || mode == MODE_OFF) st_q <= ST_RUN;
                  end
                  ST_RUN: begin
                     spin_cnt_q <= '0;
                     if (start_s2_q[g] && mode != MODE_OFF) st_q <= ST_SPIN;
                  end
                  default: st_q <= ST_IDLE;
               endcase
            end
         end

         // Applied duty, ramp limited or direct
         always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
            if (!rst_n)                          duty_q[g] <= 8'h00;
            else if (!slew_en || mode == MODE_OFF) duty_q[g] <= target;
            else if (step_tick && duty_q[g] < target) duty_q[g] <= duty_q[g] + 8'h01;
            else if (step_tick && duty_q[g] > target) duty_q[g] <= duty_q[g] - 8'h01;
         end

         // PWM prescaler: 256 counts per period at the chosen rate
         wire [3:0]  fcode = rf_q[g][3:0];
         wire [31:0] pre_len = (fcode == FREQ_FAST_CODE) ?
            32'(CLK_HZ / (FAST_HZ * 256)) :
            32'((CLK_HZ / 256) * 10 / FREQ_DHZ[fcode[2:0]]);
         logic [31:0] pre_q;
         logic [7:0]  cnt_q;
         wire pre_tick = (pre_q >= pre_len - 32'd1);
         always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
            if (!rst_n) begin
               pre_q <= '0;
               cnt_q <= '0;
            end else if (pre_tick) begin
               pre_q <= '0;
               cnt_q <= cnt_q + 8'h01;
            end else begin
               pre_q <= pre_q + 32'd1;
            end
         end

         // Output: active for duty counts, forced high during spin-up
         wire active = (cnt_q < duty_q[g]);
         wire level  = (st_q == ST_SPIN) ? 1'b1 : active;
         always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
            if (!rst_n) FAN_PWM_O[g] <= 1'b0;
            else        FAN_PWM_O[g] <= (st_q == ST_SPIN) ? 1'b1
                                        : level ^ cfg_q[g][CFG_INV_BIT];
         end
      end
   endgenerate
endmodule : afp_fan_pwm
`default_nettype wire

// >>> design/afp_pkg.sv
// Package: register map, field layout, timing constants for the fan duty generator
// Notes on behaviour
// - Inverted output at full request: low 255 counts, high one count per period.
// - Normal output at full request: high 255 counts, low one count per period.
// - Starting from standstill holds full duty for the selected spin-up time; the code holds the pin high, which is zero duty when inverted.
// - During spin-up the output is forced high continuously, no low count.
// - With early end enabled, spin-up ends on tach below minimum or timer expiry.
// - Early end needs every tach of the channel below its own minimum.
// - Clearing the early end enable makes every spin-up run its whole time unless the channel is set to disabled.
// - Spin-up code picks 0, 100, 250, 400, 700, 1000, 2000 or 4000 ms.
// - Lock makes range/frequency and ramp registers read-only.
// - Auto mode: minimum duty at low limit, linear rise to full over range.
// - Auto mode: above low limit plus range the duty is full.
// - Below the zone low limit the duty is the programmed minimum.
// - Frequency code picks 11.0 to 87.7 Hz or about 25 kHz for 1010.
// - Range code picks 2 to 80 degrees; reset code 1100 gives 32.
// - Fractional ranges use their slope but reach full at next integer.
// - Ramp enabled steps duty toward target; disabled jumps at once.
// - Each ramp step is one unit, interval 206 down to 5 ms by code.
// - Ch1 ramp in low nibble of first ramp register; ch2 high, ch3 low of second.
// - Range computation applies only above low limit and below absolute limit.
// - Zone/mode selects zone auto, full on, disabled, hottest groups or manual.
// - Any zone above its absolute limit in auto forces non-disabled channels full.
package afp_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   // Register offsets, byte addresses on the word bus are 4x
   localparam logic [7:0] OFS_RANGE_FREQ1 = 8'h5f;
   localparam logic [7:0] OFS_RANGE_FREQ2 = 8'h60;
   localparam logic [7:0] OFS_RANGE_FREQ3 = 8'h61;
   localparam logic [7:0] OFS_RAMP1       = 8'h62;
   localparam logic [7:0] OFS_RAMP23      = 8'h63;
   localparam logic [7:0] OFS_CFG1        = 8'h5c;
   localparam logic [7:0] OFS_CFG2        = 8'h5d;
   localparam logic [7:0] OFS_CFG3        = 8'h5e;
   localparam logic [7:0] OFS_MIN1        = 8'h64;
   localparam logic [7:0] OFS_LOW1        = 8'h67;
   localparam logic [7:0] OFS_ABS1        = 8'h6a;
   localparam logic [7:0] OFS_GCFG        = 8'h7f;
   localparam logic [7:0] OFS_DUTY1       = 8'h30;
   localparam logic [7:0] OFS_STATUS      = 8'h70;
   // Reset values
   localparam logic [7:0] RST_RANGE_FREQ = 8'hc3;
   localparam logic [7:0] RST_RAMP1      = 8'he0;
   localparam logic [7:0] RST_RAMP23     = 8'h00;
   localparam logic [7:0] RST_CFG        = 8'h62;
   localparam logic [7:0] RST_MIN        = 8'h80;
   localparam logic [7:0] RST_LOW        = 8'h80;
   localparam logic [7:0] RST_ABS        = 8'h64;
   localparam logic [7:0] RST_GCFG       = 8'h10;
   // Field positions
   localparam int unsigned GCFG_LOCK_BIT  = 1;
   localparam int unsigned GCFG_STARTUP_EARLY_END_ENABLE_BIT = 4;
   localparam int unsigned CFG_INV_BIT    = 4;
   localparam logic [3:0]  FREQ_FAST_CODE = 4'ha;
   localparam logic [7:0]  ABS_OFF        = 8'h80;
   // Times
   localparam int unsigned SPIN_MS [8] = '{0, 100, 250, 400, 700, 1000, 2000, 4000};
   localparam int unsigned STEP_MS [8] = '{206, 104, 69, 41, 26, 18, 10, 5};
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   // Frequency in tenths of Hz, fast code in Hz
   localparam int unsigned FREQ_DHZ [8] = '{110, 146, 219, 293, 352, 440, 586, 877};
   localparam int unsigned FAST_HZ      = 25_000;
   // Range in hundredths of degrees, and ceiling in degrees
   localparam int unsigned RANGE_CD [16] = '{200, 250, 333, 400, 500, 667, 800, 1000,
      1333, 1600, 2000, 2667, 3200, 4000, 5333, 8000};
   localparam int unsigned RANGE_CEIL [16] = '{2, 3, 4, 4, 5, 7, 8, 10,
      14, 16, 20, 27, 32, 40, 54, 80};
   typedef enum logic [2:0] {
      MODE_Z1, MODE_Z2, MODE_Z3, MODE_FULL, MODE_OFF, MODE_HOT23, MODE_HOT123, MODE_MANUAL
   } afp_mode_e;
   typedef enum {ST_IDLE, ST_SPIN, ST_RUN} afp_state_e;
   typedef struct packed {
      logic [7:0] adr;
      logic       we;
      logic [7:0] dat;
   } afp_req_s;
endpackage : afp_pkg

// >>> testbench/afp_fan_model.sv
// Behavioural fan: rotor speed follows the drive pin, tach flag once up to speed
`timescale 1ns/10ps
`default_nettype none
module afp_fan_model #(
   parameter int unsigned THRESH = 3000
) (
   // Clock and drive
   input  wire logic clk_i,
   input  wire logic drive_i,
   // Tach feedback
   output logic      tach_ok_o,
   output logic      stopped_o
);
   int unsigned speed = 0;
   // Rotor gains speed while driven and coasts down when not
   always @(posedge clk_i) begin
      if (drive_i === 1'b1 && speed < THRESH + 1000) speed <= speed + 1;
      else if (drive_i !== 1'b1 && speed != 0) speed <= speed - 1;
   end
   // All tachs of the channel read below minimum, minimum set below all ones
   assign tach_ok_o = (speed >= THRESH);
   assign stopped_o = (speed == 0);
endmodule : afp_fan_model
`default_nettype wire

// >>> testbench/afp_fan_pwm_asserts.sv
// Checker: bus handshake, spin-up hold and disabled pin level of the fan PWM
`timescale 1ns/10ps
`default_nettype none
module afp_fan_pwm_asserts #(
   parameter int unsigned NCH = 3
) (
   // Clock, reset and bus
   input  wire logic           CORE_CLK_I,
   input  wire logic           RST_N_I,
   input  wire logic           WB_CYC_I,
   input  wire logic           WB_STB_I,
   input  wire logic           WB_WE_I,
   input  wire logic [9:0]     WB_ADR_I,
   input  wire logic [3:0]     WB_SEL_I,
   input  wire logic [31:0]    WB_DAT_I,
   input  wire logic [31:0]    WB_DAT_O,
   input  wire logic           WB_ACK_O,
   // Temperatures, tach and fans
   input  wire logic [3*8-1:0] ZONE_TEMP_I,
   input  wire logic [NCH-1:0] TACH_OK_I,
   input  wire logic [NCH-1:0] FAN_START_I,
   input  wire logic [NCH-1:0] FAN_PWM_O
);
   logic [7:0] cfg_q [3];
   logic       lock_q;
   logic [7:0] age_q;
   logic       wr_take;
   logic [7:0] widx;

   // Taken write and its register index
   assign wr_take = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];
   assign widx    = WB_ADR_I[9:2];

   // Shadow of channel configuration, lock, and cycles since a configuration change
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cfg_q  <= '{default: 8'h62};
         lock_q <= 1'b0;
         age_q  <= 8'h00;
      end else begin
         if (wr_take && widx == 8'h7f && WB_DAT_I[1]) begin
            lock_q <= 1'b1;
         end
         if (wr_take && !lock_q && widx >= 8'h5c && widx <= 8'h5e) begin
            cfg_q[widx[1:0]] <= WB_DAT_I[7:0];
            age_q            <= 8'h00;
         end else if (age_q != 8'hff) begin
            age_q <= age_q + 8'h01;
         end
      end
   end

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);

   // Steps of a bus request and of a spin-up start on channel 1
   sequence s_req;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence s_spin_start;
      $rose(FAN_START_I[0]) && cfg_q[0][2:0] != 3'h0 && cfg_q[0][7:5] != 3'h4
         && !cfg_q[0][4] && !TACH_OK_I[0];
   endsequence

   property p_ack_answer;
      s_req |=> WB_ACK_O;
   endproperty
   property p_ack_single;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   property p_ack_cause;
      $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
   endproperty
   property p_dat_upper;
      WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h000000;
   endproperty
   property p_ramp1_upper;
      WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == 8'h62 |-> WB_DAT_O[7:4] == 4'he;
   endproperty
   property p_unmapped;
      WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == 8'h01 |-> WB_DAT_O == 32'h00000000;
   endproperty
   property p_spin_high;
      s_spin_start ##1 (!TACH_OK_I[0]) [*8] |-> FAN_PWM_O[0] [*3];
   endproperty
   property p_off_level;
      cfg_q[1][7:5] == 3'h4 && age_q >= 8'h08 |-> FAN_PWM_O[1] == cfg_q[1][4];
   endproperty

   a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
   a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
   a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits not zero");
   a_ramp1_upper: assert property (p_ramp1_upper) else $error("ramp 1 high bits");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_spin_high: assert property (p_spin_high) else $error("spin-up output not high");
   a_off_level: assert property (p_off_level) else $error("disabled pin not idle");
endmodule : afp_fan_pwm_asserts

bind afp_fan_pwm afp_fan_pwm_asserts #(.NCH(NCH)) u_afp_chk (
   .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ZONE_TEMP_I(ZONE_TEMP_I),
   .TACH_OK_I(TACH_OK_I), .FAN_START_I(FAN_START_I), .FAN_PWM_O(FAN_PWM_O)
);
`default_nettype wire

// >>> testbench/testbench.sv
// Bench for the fan PWM: registers, auto curve, polarity, spin-up, lock
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import afp_pkg::*;
   typedef struct packed {
      logic [23:0] temp;
      logic        we;
      logic [7:0]  adr;
      logic [7:0]  dat;
      logic [7:0]  lo;
      logic [7:0]  hi;
   } afp_row_s;
   logic        clk, rst_n, cyc, we, ack;
   logic [9:0]  adr;
   logic [31:0] wdat, rdat, r;
   logic [23:0] ztemp;
   logic [2:0]  tach_ok, stopped, start, pwm;
   int          failures, compares, hi, lo;
   // Zone temperatures, write flag, register, data, lowest and highest accepted read
   afp_row_s    rows [37] = '{
      '{24'h0, 1'b0, 8'h5f, 8'h00, 8'hc3, 8'hc3}, '{24'h0, 1'b0, 8'h60, 8'h00, 8'hc3, 8'hc3},
      '{24'h0, 1'b0, 8'h61, 8'h00, 8'hc3, 8'hc3}, '{24'h0, 1'b0, 8'h62, 8'h00, 8'he0, 8'he0},
      '{24'h0, 1'b0, 8'h63, 8'h00, 8'h00, 8'h00}, '{24'h0, 1'b0, 8'h01, 8'h00, 8'h00, 8'h00},
      '{24'h0, 1'b1, 8'h63, 8'ha5, 8'h00, 8'h00}, '{24'h0, 1'b0, 8'h63, 8'h00, 8'ha5, 8'ha5},
      '{24'h0, 1'b1, 8'h62, 8'h0d, 8'h00, 8'h00}, '{24'h0, 1'b0, 8'h62, 8'h00, 8'hed, 8'hed},
      '{24'h0, 1'b1, 8'h62, 8'h00, 8'h00, 8'h00}, '{24'h0, 1'b1, 8'h01, 8'h55, 8'h00, 8'h00},
      '{24'h0, 1'b0, 8'h01, 8'h00, 8'h00, 8'h00}, '{24'h0, 1'b1, 8'h5c, 8'h00, 8'h00, 8'h00},
      '{24'h0, 1'b1, 8'h67, 8'h32, 8'h00, 8'h00}, '{24'h0, 1'b1, 8'h64, 8'h80, 8'h00, 8'h00},
      '{24'h0, 1'b1, 8'h5f, 8'h6a, 8'h00, 8'h00}, '{24'h28, 1'b0, 8'h30, 8'h00, 8'h80, 8'h80},
      '{24'h32, 1'b0, 8'h30, 8'h00, 8'h80, 8'h80}, '{24'h36, 1'b0, 8'h30, 8'h00, 8'hbf, 8'hc0},
      '{24'h3a, 1'b0, 8'h30, 8'h00, 8'hff, 8'hff}, '{24'h46, 1'b0, 8'h30, 8'h00, 8'hff, 8'hff},
      '{24'h46, 1'b1, 8'h5f, 8'h2a, 8'h00, 8'h00}, '{24'h35, 1'b0, 8'h30, 8'h00, 8'he8, 8'hfe},
      '{24'h36, 1'b0, 8'h30, 8'h00, 8'hff, 8'hff}, '{24'h36, 1'b1, 8'h5f, 8'h6a, 8'h00, 8'h00},
      '{24'h6528, 1'b0, 8'h30, 8'h00, 8'hff, 8'hff}, '{24'h6528, 1'b1, 8'h6b, 8'h80, 8'h0, 8'h0},
      '{24'h6528, 1'b0, 8'h30, 8'h00, 8'h80, 8'h80}, '{24'h28, 1'b1, 8'h62, 8'h0f, 8'h0, 8'h0},
      '{24'h46, 1'b0, 8'h30, 8'h00, 8'h80, 8'h81}, '{24'h46, 1'b1, 8'h62, 8'h00, 8'h0, 8'h0},
      '{24'h46, 1'b0, 8'h30, 8'h00, 8'hff, 8'hff},
      '{24'h808036, 1'b1, 8'h5e, 8'hc0, 8'h00, 8'h00},
      '{24'h808036, 1'b0, 8'h32, 8'h00, 8'hbf, 8'hc0},
      '{24'h808036, 1'b1, 8'h5e, 8'ha0, 8'h00, 8'h00},
      '{24'h808036, 1'b0, 8'h32, 8'h00, 8'h80, 8'h80}};

   // Design and one fan per channel
   afp_fan_pwm #(.NCH(3)) afp_fan_pwm_inst (
      .CORE_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .ZONE_TEMP_I(ztemp), .TACH_OK_I(tach_ok), .FAN_START_I(start), .FAN_PWM_O(pwm));
   for (genvar g = 0; g < 3; g++) begin : g_fan
      afp_fan_model afp_fan_model_inst (
         .clk_i(clk), .drive_i(pwm[g]), .tach_ok_o(tach_ok[g]), .stopped_o(stopped[g]));
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One classic Wishbone cycle, request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= {a, 2'b00};
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      cyc <= 1'b0;
      check({31'h0, ack}, 32'h1);
   endtask : wb

   // Count high and low samples of one fan pin after a settling span
   task automatic measure(input int c, input int n);
      hi = 0;
      lo = 0;
      repeat (50) @(posedge clk);
      repeat (n) begin
         @(negedge clk);
         hi += (pwm[c] === 1'b1);
         lo += (pwm[c] === 1'b0);
      end
   endtask : measure

   // Bounded wait for channel 1 fan to stop or to report speed
   task automatic wait_fan(input bit tach);
      int n;
      n = 0;
      while ((tach ? tach_ok[0] : stopped[0]) !== 1'b1 && n < 10000) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, n < 10000}, 32'h1);
      @(posedge clk);
      start <= 3'b001;
      @(posedge clk);
      start <= 3'b000;
   endtask : wait_fan

   task automatic test_done();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      test_done();
   end

   initial begin
      {failures, compares, hi, lo} = '0;
      {rst_n, cyc, we, adr, wdat, ztemp, start} = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      foreach (rows[i]) begin
         ztemp <= rows[i].temp;
         if (!rows[i].we) repeat (20) @(posedge clk);
         wb(rows[i].we, rows[i].adr, rows[i].dat);
         if (!rows[i].we) check({31'h0, r >= rows[i].lo && r <= rows[i].hi}, 32'h1);
      end
      $display("table rows done");
      ztemp <= 24'h0;
      wb(1'b1, 8'h61, 8'hca);
      wb(1'b1, 8'h5e, 8'he0);
      wb(1'b1, 8'h32, 8'hff);
      measure(2, 4000);
      check({31'h0, lo > 0 && hi >= 200 * lo}, 32'h1);
      wb(1'b1, 8'h5e, 8'hf0);
      measure(2, 4000);
      check({31'h0, hi > 0 && lo >= 200 * hi}, 32'h1);
      $display("polarity done");
      ztemp <= 24'h650000;
      wb(1'b1, 8'h60, 8'hca);
      wb(1'b1, 8'h5d, 8'h80);
      measure(1, 1000);
      check(lo, 1000);
      wb(1'b1, 8'h5d, 8'h90);
      measure(1, 1000);
      check(hi, 1000);
      wb(1'b0, 8'h30, 8'h00);
      check(r, 32'hff);
      $display("disable and override done");
      ztemp <= 24'h0;
      wb(1'b1, 8'h30, 8'h00);
      wb(1'b1, 8'h5c, 8'he1);
      wait_fan(1'b0);
      measure(0, 2500);
      check(hi, 2500);
      wait_fan(1'b1);
      measure(0, 1000);
      check(lo, 1000);
      $display("spin-up done");
      wb(1'b1, 8'h7f, 8'h12);
      wb(1'b1, 8'h5f, 8'h00);
      wb(1'b0, 8'h5f, 8'h00);
      check(r, 32'h6a);
      wb(1'b1, 8'h7f, 8'h02);
      wait_fan(1'b0);
      measure(0, 6000);
      check(hi, 6000);
      $display("lock and full spin-up done");
      // Mid-run reset clears the lock and restores the range default
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      wb(1'b0, 8'h5f, 8'h00);
      check(r, 32'hc3);
      $display("mid-run reset done");
      test_done();
   end
endmodule : testbench
`default_nettype wire
